// [common/addr_mode_consts.vh]
`ifndef ADDR_MODE_CONSTS_VH
`define ADDR_MODE_CONSTS_VH
`define AM_IMP   4'h0
`define AM_IMM   4'h1
`define AM_ZPG   4'h2
`define AM_ZPX   4'h3
`define AM_ZPY   4'h4
`define AM_ABS   4'h5
`define AM_ABX   4'h6
`define AM_ABY   4'h7
`define AM_REL   4'h8
`define AM_INX   4'h9
`define AM_INY   4'hA
`define AM_ZIND  4'hB
`define AM_IND   4'hC
`define AM_AINX  4'hD
`define AM_NOP1  4'hE
`define AM_NOPN  4'hF
`define OP_OTHER 4'h0
`define OP_JUMP  4'h1
`define OP_BRA   4'h2
`define OP_STZ   4'h3
`define OP_TRB   4'h4
`define OP_TSB   4'h5
`define OP_PHX   4'h6
`define OP_PHY   4'h7
`define OP_PLX   4'h8
`define OP_PLY   4'h9
`define OP_STA   4'hA
`define OP_NOP   4'hB
`define OP_BCOND 4'hC
`define PAGE_ZERO 8'h00
`endif

// [src/opcode_decoder.v]
`timescale 1ns/1ps
`include "addr_mode_consts.vh"
module opcode_decoder (
  input  wire [7:0] opcode_in,
  output reg  [3:0] mode_out,
  output reg  [3:0] op_out,
  output reg  [1:0] nop_bytes_out
);
  wire [3:0] opcode_upper_nibble = opcode_in[7:4];
  wire [3:0] col = opcode_in[3:0];
  wire       odd_row = opcode_upper_nibble[0];
  // Row selects operation group, column selects addressing shape [RQ18]
  always @* begin
    mode_out      = `AM_IMP;
    op_out        = `OP_OTHER;
    nop_bytes_out = 2'h1;
    case (col)
      4'h0: begin
        if (odd_row) begin
          mode_out = `AM_REL; // [RQ5]
          op_out   = `OP_BCOND;
        end else if (opcode_in == 8'h80) begin
          mode_out = `AM_REL; // [RQ5]
          op_out   = `OP_BRA;
        end else if (opcode_in == 8'h20) mode_out = `AM_ABS;
        else if (opcode_in[7]) mode_out = `AM_IMM;
      end
      4'h1: mode_out = odd_row ? `AM_INY : `AM_INX;
      4'h2: begin
        if (odd_row) mode_out = `AM_ZIND;
        else if (opcode_in == 8'hA2) mode_out = `AM_IMM;
        else begin
          mode_out      = `AM_NOPN; // [RQ16]
          op_out        = `OP_NOP;
          nop_bytes_out = 2'h2;
        end
      end
      4'h4, 4'h5, 4'h6: begin
        mode_out = odd_row ? ((opcode_in == 8'h96 || opcode_in == 8'hB6) ? `AM_ZPY : `AM_ZPX) : `AM_ZPG;
        if (opcode_in == 8'h44 || opcode_in == 8'h54 || opcode_in == 8'hD4 || opcode_in == 8'hF4) begin
          mode_out      = `AM_NOPN; // [RQ16]
          op_out        = `OP_NOP;
          nop_bytes_out = 2'h2;
        end
        if (opcode_in == 8'h64 || opcode_in == 8'h74) op_out = `OP_STZ; // [RQ14]
        if (opcode_in == 8'h04) op_out = `OP_TSB; // [RQ13]
        if (opcode_in == 8'h14) begin
          mode_out = `AM_ZPG; // [RQ18]
          op_out   = `OP_TRB; // [RQ13]
        end
        if (opcode_in == 8'h85 || opcode_in == 8'h95) op_out = `OP_STA;
      end
      4'h9: mode_out = odd_row ? `AM_ABY : `AM_IMM;
      4'hA: begin
        if (opcode_in == 8'hDA) op_out = `OP_PHX; // [RQ15]
        if (opcode_in == 8'h5A) op_out = `OP_PHY; // [RQ15]
        if (opcode_in == 8'hFA) op_out = `OP_PLX; // [RQ15]
        if (opcode_in == 8'h7A) op_out = `OP_PLY; // [RQ15]
      end
      4'hC, 4'hD, 4'hE: begin
        mode_out = odd_row ? ((opcode_in == 8'hBE) ? `AM_ABY : `AM_ABX) : `AM_ABS;
        if (opcode_in == 8'h4C) op_out = `OP_JUMP;
        if (opcode_in == 8'h6C) begin
          mode_out = `AM_IND; // [RQ12]
          op_out   = `OP_JUMP;
        end
        if (opcode_in == 8'h7C) begin
          mode_out = `AM_AINX; // [RQ8]
          op_out   = `OP_JUMP;
        end
        if (opcode_in == 8'h5C || opcode_in == 8'hDC || opcode_in == 8'hFC) begin
          mode_out      = `AM_NOPN; // [RQ16]
          op_out        = `OP_NOP;
          nop_bytes_out = 2'h3;
        end
        if (opcode_in == 8'h9C || opcode_in == 8'h9E) op_out = `OP_STZ; // [RQ14]
        if (opcode_in == 8'h9C) mode_out = `AM_ABS; // [RQ18]
        if (opcode_in == 8'h0C) op_out = `OP_TSB; // [RQ13]
        if (opcode_in == 8'h1C) begin
          mode_out = `AM_ABS; // [RQ18]
          op_out   = `OP_TRB; // [RQ13]
        end
        if (opcode_in == 8'h8D || opcode_in == 8'h9D) op_out = `OP_STA;
      end
      4'h3, 4'h7, 4'hB, 4'hF: begin
        mode_out = `AM_NOP1; // [RQ16]
        op_out   = `OP_NOP;
      end
      default: begin
        if (opcode_in == 8'h89) mode_out = `AM_IMM;
        else mode_out = `AM_IMP;
      end
    endcase
    if (opcode_in == 8'h81 || opcode_in == 8'h91 || opcode_in == 8'h92 || opcode_in == 8'h99) op_out = `OP_STA;
  end
endmodule // opcode_decoder

// [src/cpu_address_mode_unit.v]
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Zero page fetches one operand byte; high address byte forced to zero.
// RQ2: Absolute indexed address is two-byte base plus selected index register.
// RQ3: Zero page indexed address is operand byte plus index, in page zero.
// RQ4: Zero page indexed sum drops its carry and wraps inside page zero.
// RQ5: Relative mode serves branches only; target is PC plus signed offset.
// RQ6: Indirect X adds operand to first index, carry dropped, page-zero pointer.
// RQ7: Indirect X reads low then high byte, both inside page zero.
// RQ8: Jump indexed indirect adds operand to first index, reads target there.
// RQ9: Indirect Y adds pointer low byte to second index for low address.
// RQ10: Indirect Y carry joins next pointer byte to form high address.
// RQ11: Zero page indirect reads two consecutive pointer bytes, low then high.
// RQ12: Jump indirect reads a 16-bit target and loads the program counter.
// RQ13: Test-and-clear and test-and-set memory bits are read-modify-write.
// RQ14: Store zero writes a zero byte, using no register contents.
// RQ15: Both index registers can be pushed and pulled on the stack.
// RQ16: Unassigned opcodes run as no-operations of fixed length.
// RQ17: Indexed page crossing adds a cycle, except store accumulator and zero.
// RQ18: Opcode upper nibble picks row, lower nibble column of the map.
// RQ19: Memory returns the addressed byte for every operand and pointer read.
`include "addr_mode_consts.vh"
module cpu_address_mode_unit (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire        start_in,
  input  wire [15:0] pc_in,
  input  wire [7:0]  index_first_in,
  input  wire [7:0]  index_second_in,
  input  wire [7:0]  accum_in,
  input  wire [7:0]  stack_ptr_in,
  input  wire [7:0]  data_in,
  output reg  [15:0] addr_out,
  output reg  [7:0]  data_out,
  output reg         write_out,
  output reg         busy_out,
  output reg         done_out,
  output reg  [15:0] eff_addr_out,
  output reg  [15:0] next_pc_out,
  output reg  [3:0]  mode_out,
  output reg  [3:0]  op_out,
  output reg         page_cross_out,
  output reg         zero_test_out,
  output reg  [7:0]  pulled_out,
  output reg  [3:0]  cycles_out
);
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_OPC   = 4'h1;
  localparam [3:0] ST_OPL   = 4'h2;
  localparam [3:0] ST_OPH   = 4'h3;
  localparam [3:0] ST_PTRL  = 4'h4;
  localparam [3:0] ST_PTRH  = 4'h5;
  localparam [3:0] ST_RMWR  = 4'h6;
  localparam [3:0] ST_RMWW  = 4'h7;
  localparam [3:0] ST_STK   = 4'h8;
  localparam [3:0] ST_SKIP  = 4'h9;
  localparam [3:0] ST_DONE  = 4'hA;

  reg  [3:0]  state_r;
  reg  [15:0] pc_r;
  reg  [7:0]  opcode_r;
  reg  [7:0]  lo_r;
  reg  [15:0] ptr_r;
  reg  [1:0]  skip_r;
  wire [3:0]  mode_w;
  wire [3:0]  op_w;
  wire [1:0]  nop_len_w;

  opcode_decoder u_dec (
    .opcode_in     (opcode_r),
    .mode_out      (mode_w),
    .op_out        (op_w),
    .nop_bytes_out (nop_len_w)
  );

  wire [7:0] idx_w = (mode_w == `AM_ABY || mode_w == `AM_ZPY) ? index_second_in : index_first_in;
  wire [8:0] lo_sum_w = {1'b0, lo_r} + {1'b0, idx_w};
  wire [8:0] iy_sum_w = {1'b0, lo_r} + {1'b0, index_second_in};
  wire       is_push = (op_w == `OP_PHX) || (op_w == `OP_PHY);
  wire       is_pull = (op_w == `OP_PLX) || (op_w == `OP_PLY);
  wire       no_penalty = (op_w == `OP_STA) || (op_w == `OP_STZ);
  wire [7:0] rmw_w = (op_w == `OP_TSB) ? (data_in | accum_in) : (data_in & ~accum_in);

  always @(posedge clock_in) begin
    if (rst_in) begin
      state_r        <= ST_IDLE;
      pc_r           <= 16'h0000;
      opcode_r       <= 8'h00;
      lo_r           <= 8'h00;
      ptr_r          <= 16'h0000;
      skip_r         <= 2'h0;
      addr_out       <= 16'h0000;
      data_out       <= 8'h00;
      write_out      <= 1'b0;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      eff_addr_out   <= 16'h0000;
      next_pc_out    <= 16'h0000;
      mode_out       <= 4'h0;
      op_out         <= 4'h0;
      page_cross_out <= 1'b0;
      zero_test_out  <= 1'b0;
      pulled_out     <= 8'h00;
      cycles_out     <= 4'h0;
    end else begin
      done_out  <= 1'b0;
      write_out <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_in) begin
            addr_out       <= pc_in;
            pc_r           <= pc_in + 16'h0001;
            busy_out       <= 1'b1;
            page_cross_out <= 1'b0;
            cycles_out     <= 4'h1;
            state_r        <= ST_OPC;
          end
        end
        ST_OPC: begin
          // Memory answers every read in the cycle after the address [RQ19]
          opcode_r   <= data_in;
          cycles_out <= cycles_out + 4'h1;
          addr_out   <= pc_r;
          state_r    <= ST_OPL;
        end
        ST_OPL: begin
          mode_out   <= mode_w;
          op_out     <= op_w;
          lo_r       <= data_in;
          cycles_out <= cycles_out + 4'h1;
          case (mode_w)
            `AM_IMP: begin
              next_pc_out <= pc_r;
              if (is_push) begin
                addr_out  <= {8'h01, stack_ptr_in};
                data_out  <= (op_w == `OP_PHX) ? index_first_in : index_second_in; // [RQ15]
                write_out <= 1'b1;
                state_r   <= ST_DONE;
              end else if (is_pull) begin
                addr_out <= {8'h01, stack_ptr_in + 8'h01}; // [RQ15]
                state_r  <= ST_STK;
              end else state_r <= ST_DONE;
            end
            `AM_NOP1: begin
              next_pc_out <= pc_r; // [RQ16]
              state_r     <= ST_DONE;
            end
            `AM_NOPN: begin
              pc_r    <= pc_r + {14'h0000, nop_len_w} - 16'h0001; // [RQ16]
              skip_r  <= opcode_in_is_5c(opcode_r) ? 2'h3 : ((opcode_r[3:0] == 4'h2) ? 2'h0 : 2'h1);
              state_r <= ST_SKIP;
            end
            `AM_IMM, `AM_REL: begin
              pc_r    <= pc_r + 16'h0001;
              state_r <= ST_PTRL;
            end
            `AM_ZPG: begin
              pc_r         <= pc_r + 16'h0001;
              eff_addr_out <= {`PAGE_ZERO, data_in}; // [RQ1]
              state_r      <= ST_PTRL;
            end
            `AM_ZPX, `AM_ZPY, `AM_INX: begin
              pc_r    <= pc_r + 16'h0001;
              ptr_r   <= {`PAGE_ZERO, data_in + idx_w}; // [RQ3] [RQ4] [RQ6]
              addr_out <= {`PAGE_ZERO, data_in + idx_w};
              state_r <= (mode_w == `AM_INX) ? ST_PTRL : ST_SKIP;
              skip_r  <= 2'h0;
            end
            `AM_INY, `AM_ZIND: begin
              pc_r     <= pc_r + 16'h0001;
              ptr_r    <= {`PAGE_ZERO, data_in}; // [RQ9] [RQ11]
              addr_out <= {`PAGE_ZERO, data_in};
              state_r  <= ST_PTRL;
            end
            default: begin
              pc_r     <= pc_r + 16'h0001;
              addr_out <= pc_r + 16'h0001;
              state_r  <= ST_OPH;
            end
          endcase
        end
        ST_OPH: begin
          pc_r       <= pc_r + 16'h0001;
          cycles_out <= cycles_out + 4'h1;
          next_pc_out <= pc_r + 16'h0001;
          case (mode_w)
            `AM_ABX, `AM_ABY: begin
              eff_addr_out   <= {data_in, lo_r} + {8'h00, idx_w}; // [RQ2]
              page_cross_out <= lo_sum_w[8] & ~no_penalty; // [RQ17]
              if (lo_sum_w[8] && !no_penalty) cycles_out <= cycles_out + 4'h2; // [RQ17]
              state_r        <= ST_RMWR;
            end
            `AM_IND, `AM_AINX: begin
              ptr_r    <= {data_in, lo_r} + {8'h00, (mode_w == `AM_AINX) ? index_first_in : 8'h00}; // [RQ8] [RQ12]
              addr_out <= {data_in, lo_r} + {8'h00, (mode_w == `AM_AINX) ? index_first_in : 8'h00};
              state_r  <= ST_PTRL;
            end
            default: begin
              eff_addr_out <= {data_in, lo_r};
              if (op_w == `OP_JUMP) next_pc_out <= {data_in, lo_r};
              state_r <= ST_RMWR;
            end
          endcase
        end
        ST_PTRL: begin
          cycles_out <= cycles_out + 4'h1;
          next_pc_out <= pc_r;
          case (mode_w)
            `AM_REL: begin
              eff_addr_out <= pc_r + {{8{lo_r[7]}}, lo_r}; // [RQ5]
              if (op_w == `OP_BRA) next_pc_out <= pc_r + {{8{lo_r[7]}}, lo_r}; // [RQ5]
              state_r <= ST_DONE;
            end
            `AM_IMM: state_r <= ST_DONE;
            `AM_ZPG: state_r <= ST_RMWR;
            default: begin
              lo_r     <= data_in;
              // Indirect X keeps its second read in page zero [RQ7]
              addr_out <= (mode_w == `AM_IND || mode_w == `AM_AINX) ? ptr_r + 16'h0001 : {`PAGE_ZERO, ptr_r[7:0] + 8'h01};
              state_r  <= ST_PTRH;
            end
          endcase
        end
        ST_PTRH: begin
          cycles_out <= cycles_out + 4'h1;
          if (mode_w == `AM_INY) begin
            eff_addr_out   <= {data_in + {7'h00, iy_sum_w[8]}, iy_sum_w[7:0]}; // [RQ9] [RQ10]
            page_cross_out <= iy_sum_w[8] & ~no_penalty; // [RQ17]
            if (iy_sum_w[8] && !no_penalty) cycles_out <= cycles_out + 4'h2;
          end else eff_addr_out <= {data_in, lo_r}; // [RQ7] [RQ11]
          if (op_w == `OP_JUMP) next_pc_out <= {data_in, lo_r}; // [RQ8] [RQ12]
          state_r <= (op_w == `OP_JUMP) ? ST_DONE : ST_RMWR;
        end
        ST_SKIP: begin
          cycles_out <= cycles_out + 4'h1;
          if (mode_w == `AM_NOPN) begin
            next_pc_out <= pc_r;
            if (skip_r == 2'h0) state_r <= ST_DONE;
            else skip_r <= skip_r - 2'h1;
          end else begin
            eff_addr_out <= ptr_r;
            state_r      <= ST_RMWR;
          end
        end
        ST_RMWR: begin
          addr_out <= eff_addr_out;
          if (op_w == `OP_STZ) begin
            data_out  <= 8'h00; // [RQ14]
            write_out <= 1'b1;
            state_r   <= ST_DONE;
          end else if (op_w == `OP_TRB || op_w == `OP_TSB) state_r <= ST_RMWW;
          else state_r <= ST_DONE;
        end
        ST_RMWW: begin
          // One read then one write keeps the modify cycle bus-quiet [RQ13]
          zero_test_out <= ((data_in & accum_in) == 8'h00);
          data_out      <= rmw_w;
          write_out     <= 1'b1;
          cycles_out    <= cycles_out + 4'h2;
          state_r       <= ST_DONE;
        end
        ST_STK: begin
          pulled_out <= data_in; // [RQ15]
          cycles_out <= cycles_out + 4'h2;
          state_r    <= ST_DONE;
        end
        ST_DONE: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  function opcode_in_is_5c;
    input [7:0] op;
    begin
      opcode_in_is_5c = (op == 8'h5C);
    end
  endfunction
endmodule // cpu_address_mode_unit

// [sim/mem_model.sv]
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        write_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:65535];
  // Reads are combinational: the core takes the byte at the edge after it drives the address
  always @(posedge clock_in) begin
    if (write_in)
      mem[addr_in] <= wdata_in;
  end
  assign rdata_out = mem[addr_in];
endmodule // mem_model

// [sim/addr_mode_props.sv]
`timescale 1ns/1ps
`include "addr_mode_consts.vh"
module addr_mode_props (
  input wire        clock_in,
  input wire        rst_in,
  input wire        start_in,
  input wire [7:0]  index_first_in,
  input wire [7:0]  index_second_in,
  input wire [7:0]  accum_in,
  input wire [7:0]  stack_ptr_in,
  input wire [15:0] addr_out,
  input wire [7:0]  data_out,
  input wire        write_out,
  input wire        busy_out,
  input wire        done_out,
  input wire [15:0] eff_addr_out,
  input wire [3:0]  mode_out,
  input wire [3:0]  op_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_zpg_page; done_out && mode_out == `AM_ZPG |-> eff_addr_out[15:8] == 8'h00; endproperty
  a_zpg_page: assert property (p_zpg_page) else $error("zero page result off page zero");
  property p_zpx_page;
    done_out && (mode_out == `AM_ZPX || mode_out == `AM_ZPY) |-> eff_addr_out[15:8] == 8'h00;
  endproperty
  a_zpx_page: assert property (p_zpx_page) else $error("indexed zero page result crossed page");
  property p_zpg_write; write_out && mode_out == `AM_ZPG |-> addr_out[15:8] == 8'h00; endproperty
  a_zpg_write: assert property (p_zpg_write) else $error("zero page write off page zero");
  property p_rel_branch; done_out && mode_out == `AM_REL |-> op_out == `OP_BRA || op_out == `OP_BCOND; endproperty
  a_rel_branch: assert property (p_rel_branch) else $error("relative mode on a non-branch");
  property p_stz_zero; write_out && op_out == `OP_STZ |-> data_out == 8'h00; endproperty
  a_stz_zero: assert property (p_stz_zero) else $error("store zero wrote nonzero");
  property p_push_addr;
    write_out && (op_out == `OP_PHX || op_out == `OP_PHY) |-> addr_out == {8'h01, stack_ptr_in};
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push off the stack slot");
  property p_phx_data; write_out && op_out == `OP_PHX |-> data_out == index_first_in; endproperty
  a_phx_data: assert property (p_phx_data) else $error("push wrote wrong first index");
  property p_phy_data; write_out && op_out == `OP_PHY |-> data_out == index_second_in; endproperty
  a_phy_data: assert property (p_phy_data) else $error("push wrote wrong second index");
  property p_tsb_bits; write_out && op_out == `OP_TSB |-> (data_out & accum_in) == accum_in; endproperty
  a_tsb_bits: assert property (p_tsb_bits) else $error("set bits left a mask bit clear");
  property p_trb_bits; write_out && op_out == `OP_TRB |-> (data_out & accum_in) == 8'h00; endproperty
  a_trb_bits: assert property (p_trb_bits) else $error("clear bits left a mask bit set");
  // Decode and operand fetch cannot finish in under two busy cycles
  property p_start_busy; start_in && !busy_out |=> busy_out [*2]; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not followed by busy");
  c_bra: cover property (done_out && op_out == `OP_BRA);
  c_tsb: cover property (write_out && op_out == `OP_TSB);
  c_iny: cover property (done_out && mode_out == `AM_INY);
endmodule // addr_mode_props
bind cpu_address_mode_unit addr_mode_props u_props (.clock_in, .rst_in, .start_in, .index_first_in, .index_second_in,
  .accum_in, .stack_ptr_in, .addr_out, .data_out, .write_out, .busy_out, .done_out, .eff_addr_out, .mode_out, .op_out);

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "addr_mode_consts.vh"
module tb_top;
  typedef struct packed {logic [3:0] mode; logic [3:0] op; int sel; logic [24:0] val;} exp_t;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        start_in = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0]  x = 8'h00, y = 8'h00, acc = 8'h00, sp = 8'h00;
  wire  [15:0] addr_out, eff_addr_out, next_pc_out;
  wire  [7:0]  data_out, data_in, pulled_out;
  wire  [3:0]  mode_out, op_out;
  wire         write_out, busy_out, done_out, page_cross_out, zero_test_out;
  logic [23:0] wr = 24'hFFFFFF;
  exp_t        q[$];
  exp_t        em;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  localparam logic [7:0] OPS [0:27] = '{8'h05, 8'h1D, 8'h19, 8'h15, 8'hB6, 8'h01, 8'h11, 8'h12, 8'h6C, 8'h7C,
    8'h80, 8'h64, 8'h04, 8'h1C, 8'hDA, 8'h5A, 8'hFA, 8'h7A, 8'h02, 8'h03, 8'h9D, 8'h10, 8'h4C, 8'h14, 8'h9C,
    8'h5C, 8'h44, 8'hA9};

  cpu_address_mode_unit dut (.clock_in(clock_in), .rst_in(rst_in), .start_in(start_in), .pc_in(pc_in),
    .index_first_in(x), .index_second_in(y), .accum_in(acc), .stack_ptr_in(sp), .data_in(data_in),
    .addr_out(addr_out), .data_out(data_out), .write_out(write_out), .busy_out(busy_out), .done_out(done_out),
    .eff_addr_out(eff_addr_out), .next_pc_out(next_pc_out), .mode_out(mode_out), .op_out(op_out),
    .page_cross_out(page_cross_out), .zero_test_out(zero_test_out), .pulled_out(pulled_out), .cycles_out());
  mem_model u_mem (.clock_in(clock_in), .addr_in(addr_out), .wdata_in(data_out), .write_in(write_out),
    .rdata_out(data_in));

  always #20 clock_in = ~clock_in;

  function automatic logic [7:0] mr(input logic [15:0] a);
    return u_mem.mem[a];
  endfunction

  task test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Pointers sit one below the page end on the first pass, so page-zero wrap is always hit
  task issue(input logic [7:0] opc, input int i);
    logic [7:0]  b1, b2, z, z1, s1, m;
    logic [15:0] a;
    exp_t        e;
    int          k;
    b1 = $urandom;
    b2 = $urandom;
    pc_in = 16'h0200 + 16'($urandom % 32'hFC00);
    x = $urandom;
    y = $urandom;
    acc = $urandom;
    sp = 8'($urandom % 255);
    if (i == 0) begin
      x = x | 8'h01;
      y = y | 8'h01;
      b1 = (opc == 8'h15 || opc == 8'h01) ? 8'hFF - x : 8'hFF;
    end
    u_mem.mem[pc_in] = opc;
    u_mem.mem[pc_in + 16'h1] = b1;
    u_mem.mem[pc_in + 16'h2] = b2;
    z = (opc == 8'h01) ? b1 + x : b1;
    z1 = z + 8'h01;
    s1 = sp + 8'h01;
    a = {b2, b1} + ((opc == 8'h19) ? {8'h00, y} : {8'h00, x});
    m = mr({8'h00, b1});
    case (opc)
      8'h05: e = '{`AM_ZPG, `OP_OTHER, 0, {17'h0, b1}};
      8'h1D: e = '{`AM_ABX, `OP_OTHER, 5, {8'h0, a[15:8] != b2, a}};
      8'h19: e = '{`AM_ABY, `OP_OTHER, 5, {8'h0, a[15:8] != b2, a}};
      8'h15: e = '{`AM_ZPX, `OP_OTHER, 0, {17'h0, 8'(b1 + x)}};
      8'hB6: e = '{`AM_ZPY, `OP_OTHER, 0, {17'h0, 8'(b1 + y)}};
      8'h01: e = '{`AM_INX, `OP_OTHER, 0, {9'h0, mr({8'h00, z1}), mr({8'h00, z})}};
      8'h11: e = '{`AM_INY, `OP_OTHER, 0, {9'h0, {mr({8'h00, z1}), mr({8'h00, z})} + {8'h00, y}}};
      8'h12: e = '{`AM_ZIND, `OP_OTHER, 0, {9'h0, mr({8'h00, z1}), mr({8'h00, z})}};
      8'h6C: e = '{`AM_IND, `OP_JUMP, 0, {9'h0, mr({b2, b1} + 16'h1), mr({b2, b1})}};
      8'h7C: e = '{`AM_AINX, `OP_JUMP, 0, {9'h0, mr(a + 16'h1), mr(a)}};
      8'h80: e = '{`AM_REL, `OP_BRA, 1, {9'h0, pc_in + 16'h2 + {{8{b1[7]}}, b1}}};
      8'h64: e = '{`AM_ZPG, `OP_STZ, 2, {9'h0, b1, 8'h00}};
      8'h04: e = '{`AM_ZPG, `OP_TSB, 4, {(m & acc) == 8'h00, 8'h00, b1, m | acc}};
      8'h1C: e = '{`AM_ABS, `OP_TRB, 4, {(mr({b2, b1}) & acc) == 8'h00, b2, b1, mr({b2, b1}) & ~acc}};
      8'hDA: e = '{`AM_IMP, `OP_PHX, 2, {9'h001, sp, x}};
      8'h5A: e = '{`AM_IMP, `OP_PHY, 2, {9'h001, sp, y}};
      8'hFA: e = '{`AM_IMP, `OP_PLX, 3, {17'h0, mr({8'h01, s1})}};
      8'h7A: e = '{`AM_IMP, `OP_PLY, 3, {17'h0, mr({8'h01, s1})}};
      8'h02, 8'h44: e = '{`AM_NOPN, `OP_NOP, 1, {9'h0, pc_in + 16'h2}};
      8'h5C: e = '{`AM_NOPN, `OP_NOP, 1, {9'h0, pc_in + 16'h3}};
      8'h9D: e = '{`AM_ABX, `OP_STA, 5, {9'h0, a}};
      8'h10: e = '{`AM_REL, `OP_BCOND, 0, {9'h0, pc_in + 16'h2 + {{8{b1[7]}}, b1}}};
      8'h4C: e = '{`AM_ABS, `OP_JUMP, 1, {9'h0, b2, b1}};
      8'h14: e = '{`AM_ZPG, `OP_TRB, 4, {(m & acc) == 8'h00, 8'h00, b1, m & ~acc}};
      8'h9C: e = '{`AM_ABS, `OP_STZ, 2, {1'h0, b2, b1, 8'h00}};
      8'hA9: e = '{`AM_IMM, `OP_OTHER, 1, {9'h0, pc_in + 16'h2}};
      default: e = '{`AM_NOP1, `OP_NOP, 1, {9'h0, pc_in + 16'h1}};
    endcase
    q.push_back(e);
    start_in = 1'b1;
    @(negedge clock_in);
    start_in = 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 40) begin
      @(negedge clock_in);
      k++;
    end
    if (k == 40) begin
      n_errors++;
      $display("[ERR] %0t done %h expected %h", $time, done_out, 1'b1);
    end
    @(negedge clock_in);
  endtask

  always @(posedge clock_in) begin
    if (write_out === 1'b1)
      wr = {addr_out, data_out};
    if (done_out === 1'b1 && q.size() > 0) begin
      em = q.pop_front();
      check({mode_out, op_out}, {em.mode, em.op});
      case (em.sel)
        0: check(eff_addr_out, em.val[15:0]);
        1: check(next_pc_out, em.val[15:0]);
        2: check(wr, em.val[23:0]);
        3: check(pulled_out, em.val[7:0]);
        4: check({zero_test_out, wr}, em.val);
        5: check({page_cross_out, eff_addr_out}, em.val[16:0]);
        default: ;
      endcase
      wr = 24'hFFFFFF;
    end
  end

  // Some 170 instructions of at most a dozen cycles each; the ceiling leaves wide margin
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    void'($urandom(61680));
    for (int a = 0; a < 65536; a++)
      u_mem.mem[a] = $urandom;
    repeat (4) @(negedge clock_in);
    rst_in = 1'b0;
    for (int i = 0; i < 6; i++)
      foreach (OPS[j])
        issue(OPS[j], i);
    repeat (3) @(negedge clock_in);
    test_done();
  end
endmodule // tb_top
